/* File: hdl/brake_seq_pkg.sv */
/*
 package for the holding-brake sequencer: timing constants, state encoding,
 parameter register layout. assumes a 40 MHz device clock.
*/
package brake_seq_pkg;
	localparam int unsigned CLK_HZ           = 40_000_000;
	localparam int unsigned TICK_MS          = 1;
	localparam int unsigned TICK_CYCLES      = CLK_HZ / 1000 * TICK_MS;
	localparam logic [15:0] TICK_LAST        = 16'(TICK_CYCLES - 1);
	localparam logic [7:0]  BRAKE_OUT_FUNC   = 8'h12; // function code 18
	localparam logic [15:0] CMD_DELAY_RST    = 16'h00FA; // 250 ms
	localparam logic [15:0] STILL_OFF_RST    = 16'h0096; // 150 ms
	localparam logic [15:0] SPEED_THR_RST    = 16'h0064; // 10.0 rpm, 0.1 rpm units
	localparam logic [15:0] OFF_WAIT_RST     = 16'h01F4; // 500 ms
	localparam int unsigned ROT_HOLD_MS      = 50;
	localparam logic [15:0] ROT_HOLD_TICKS   = 16'(ROT_HOLD_MS);
	localparam logic [2:0]  ADDR_CMD_DELAY   = 3'h0;
	localparam logic [2:0]  ADDR_STILL_OFF   = 3'h1;
	localparam logic [2:0]  ADDR_SPEED_THR   = 3'h2;
	localparam logic [2:0]  ADDR_OFF_WAIT    = 3'h3;
	localparam logic [2:0]  ADDR_DO_CFG      = 3'h4;
	localparam logic [2:0]  ADDR_STATUS      = 3'h5;
	localparam logic [15:0] DO_CFG_RST       = 16'h0000;

	typedef enum logic [2:0] {
		ST_OFF      = 3'b000,
		ST_RUN      = 3'b001,
		ST_STILL    = 3'b010,
		ST_ROT_WAIT = 3'b011,
		ST_ROT_HOLD = 3'b100
	} seq_state_e;

	typedef struct packed {
		logic [2:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} reg_req_s;
endpackage : brake_seq_pkg

/* File: hdl/servo_brake_sequencer.sv */
/*
 holding-brake sequencer: brake output routing, motor power gating, shutdown
 sequences for standstill, rotation and fault. assumes speed, enable and fault
 inputs synchronous to mclk and a register port with read data one cycle later.
*/
`timescale 1ns/1ps
`default_nettype none
module servo_brake_sequencer (
	input  wire logic                      mclk,
	input  wire logic                      arst_n,
	input  wire brake_seq_pkg::reg_req_s   req,
	output logic [15:0]                    rdata,
	input  wire logic                      servo_enable,
	input  wire logic [15:0]               motor_speed,
	input  wire logic                      drive_fault,
	output logic [7:0]                     do_pins,
	output logic                           motor_power,
	output logic                           cmd_ready
);
	import brake_seq_pkg::*;

	seq_state_e  state, next_state;
	logic [15:0] tick_cnt, next_tick_cnt;
	logic [15:0] ms_cnt, next_ms_cnt;
	logic [15:0] cmd_delay, still_off, speed_thr, off_wait, do_cfg;
	logic [15:0] next_cmd_delay, next_still_off, next_speed_thr, next_off_wait, next_do_cfg;
	logic [15:0] next_rdata;
	logic        brake_drive_signal, next_brake;
	logic        next_power, next_cmd_ready;
	logic [7:0]  next_do_pins;
	logic        stationary;
	logic        tick;

	// register writes and reads
	always_comb begin
		next_cmd_delay = cmd_delay;
		next_still_off = still_off;
		next_speed_thr = speed_thr;
		next_off_wait  = off_wait;
		next_do_cfg    = do_cfg;
		next_rdata     = 16'h0000;
		if (req.wr) begin
			case (req.addr)
				ADDR_CMD_DELAY: next_cmd_delay = req.wdata;
				ADDR_STILL_OFF: next_still_off = req.wdata;
				ADDR_SPEED_THR: next_speed_thr = req.wdata;
				ADDR_OFF_WAIT:  next_off_wait  = req.wdata;
				ADDR_DO_CFG:    next_do_cfg    = req.wdata;
				default:        ;
			endcase
		end
		if (req.rd) begin
			case (req.addr)
				ADDR_CMD_DELAY: next_rdata = cmd_delay;
				ADDR_STILL_OFF: next_rdata = still_off;
				ADDR_SPEED_THR: next_rdata = speed_thr;
				ADDR_OFF_WAIT:  next_rdata = off_wait;
				ADDR_DO_CFG:    next_rdata = do_cfg;
				ADDR_STATUS:    next_rdata = {10'h000, cmd_ready, motor_power, brake_drive_signal, 3'(state)};
				default:        next_rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cmd_delay <= CMD_DELAY_RST;
			still_off <= STILL_OFF_RST;
			speed_thr <= SPEED_THR_RST;
			off_wait  <= OFF_WAIT_RST;
			do_cfg    <= DO_CFG_RST;
			rdata     <= 16'h0000;
		end else begin
			cmd_delay <= next_cmd_delay;
			still_off <= next_still_off;
			speed_thr <= next_speed_thr;
			off_wait  <= next_off_wait;
			do_cfg    <= next_do_cfg;
			rdata     <= next_rdata;
		end
	end

	assign stationary = (motor_speed < speed_thr);
	assign tick = (tick_cnt == TICK_LAST);

	// sequencer and millisecond timer
	always_comb begin
		next_state = state;
		next_tick_cnt = tick ? 16'h0000 : tick_cnt + 16'h0001;
		next_ms_cnt = (tick && ms_cnt != 16'hFFFF) ? ms_cnt + 16'h0001 : ms_cnt;
		case (state)
			ST_OFF: begin
				if (servo_enable && !drive_fault)
					next_state = ST_RUN;
			end
			ST_RUN: begin
				if (!servo_enable)
					next_state = stationary ? ST_STILL : ST_ROT_WAIT;
			end
			ST_STILL: begin
				if (ms_cnt >= still_off)
					next_state = ST_OFF;
			end
			ST_ROT_WAIT: begin
				if (stationary || ms_cnt >= off_wait)
					next_state = ST_ROT_HOLD;
			end
			ST_ROT_HOLD: begin
				if (ms_cnt >= ROT_HOLD_TICKS)
					next_state = ST_OFF;
			end
			default: next_state = ST_OFF;
		endcase
		if (drive_fault)
			next_state = ST_OFF;
		if (next_state != state) begin
			next_tick_cnt = 16'h0000;
			next_ms_cnt = 16'h0000;
		end
	end

	// outputs decoded from the next state
	always_comb begin
		next_brake = (next_state == ST_RUN) || (next_state == ST_ROT_WAIT);
		next_power = (next_state != ST_OFF);
		next_cmd_ready = (state == ST_RUN) && (next_state == ST_RUN) && (ms_cnt >= cmd_delay);
		next_do_pins = 8'h00;
		if (do_cfg[15:8] == BRAKE_OUT_FUNC)
			next_do_pins[do_cfg[2:0]] = next_brake ^ do_cfg[3];
		else
			next_do_pins = 8'h00;
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state              <= ST_OFF;
			tick_cnt           <= 16'h0000;
			ms_cnt             <= 16'h0000;
			brake_drive_signal <= 1'b0;
			motor_power        <= 1'b0;
			cmd_ready          <= 1'b0;
			do_pins            <= 8'h00;
		end else begin
			state              <= next_state;
			tick_cnt           <= next_tick_cnt;
			ms_cnt             <= next_ms_cnt;
			brake_drive_signal <= next_brake;
			motor_power        <= next_power;
			cmd_ready          <= next_cmd_ready;
			do_pins            <= next_do_pins;
		end
	end

	property p_fault_off;
		@(posedge mclk) disable iff (!arst_n) drive_fault |=> (!motor_power && !brake_drive_signal);
	endproperty
	a_fault_off: assert property (p_fault_off) else $error("fault did not drop power and brake");

	property p_enable_on;
		@(posedge mclk) disable iff (!arst_n)
			(state == ST_OFF && servo_enable && !drive_fault) |=> (brake_drive_signal && motor_power);
	endproperty
	a_enable_on: assert property (p_enable_on) else $error("enable did not raise brake and power");

	property p_still_off;
		@(posedge mclk) disable iff (!arst_n)
			(state == ST_RUN && !servo_enable && stationary && !drive_fault) |=> (!brake_drive_signal && motor_power);
	endproperty
	a_still_off: assert property (p_still_off) else $error("standstill stop wrong");

	property p_rot_hold;
		@(posedge mclk) disable iff (!arst_n)
			(state == ST_RUN && !servo_enable && !stationary && !drive_fault) |=> brake_drive_signal;
	endproperty
	a_rot_hold: assert property (p_rot_hold) else $error("rotating stop dropped brake early");

	property p_rot_release;
		@(posedge mclk) disable iff (!arst_n)
			(state == ST_ROT_WAIT && stationary && !drive_fault) |=> (!brake_drive_signal && state == ST_ROT_HOLD);
	endproperty
	a_rot_release: assert property (p_rot_release) else $error("brake not released at threshold");

	property p_rot_power;
		@(posedge mclk) disable iff (!arst_n)
			(state == ST_ROT_HOLD && ms_cnt < ROT_HOLD_TICKS && !drive_fault) |=> motor_power;
	endproperty
	a_rot_power: assert property (p_rot_power) else $error("power dropped during hold");

	property p_timer_restart;
		@(posedge mclk) disable iff (!arst_n) (state != $past(state)) |-> (ms_cnt == 16'h0000);
	endproperty
	a_timer_restart: assert property (p_timer_restart) else $error("timer not restarted");

	property p_do_route;
		@(posedge mclk) disable iff (!arst_n)
			(do_cfg[15:8] == BRAKE_OUT_FUNC && !(req.wr && req.addr == ADDR_DO_CFG))
			|=> (do_pins[do_cfg[2:0]] == (brake_drive_signal ^ do_cfg[3]));
	endproperty
	a_do_route: assert property (p_do_route) else $error("brake pin routing wrong");
endmodule : servo_brake_sequencer
`default_nettype wire

/* File: dv/brake_partner.sv */
/*
 motor and host beside the sequencer: motor turns only while powered and commanded.
 assumes the bench picks the brake pin out of do_pins and drives spin.
*/
`timescale 1ns/1ps
`default_nettype none
module brake_partner (
	input  wire logic        mclk,
	input  wire logic        arst_n,
	input  wire logic        brake_drv,
	input  wire logic        power,
	input  wire logic        cmd_ready,
	input  wire logic        spin,
	output logic [15:0]      speed
);
	logic cmd_live;
	// host holds commands
	// host starts motion only once ready; the command stays live until power or spin goes
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cmd_live <= 1'b0;
		end else begin
			cmd_live <= spin && power && (cmd_live || (cmd_ready && brake_drv));
		end
	end
	// motor stops once power goes or the brake engages
	assign speed = (cmd_live && power && brake_drv) ? 16'h01F4 : 16'h0000;
endmodule : brake_partner
`default_nettype wire

/* File: dv/servo_brake_sequencer_tb.sv */
/*
 testbench for the holding-brake sequencer: register table, shutdown paths, fault.
 assumes the partner motor model and a 40 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module servo_brake_sequencer_tb;
	import brake_seq_pkg::*;
	typedef struct packed { logic [2:0] addr; logic [15:0] exp; } row_s;
	logic        mclk = 1'b0;
	logic        arst_n = 1'b0;
	reg_req_s    req = '0;
	logic [15:0] rdata;
	logic        servo_enable = 1'b0;
	logic [15:0] motor_speed;
	logic        drive_fault = 1'b0;
	logic [7:0]  do_pins;
	logic        motor_power;
	logic        cmd_ready;
	logic        spin = 1'b0;
	int          err_count = 0;
	int          total_checks = 0;
	row_s        rows [7] = '{'{ADDR_CMD_DELAY, CMD_DELAY_RST}, '{ADDR_STILL_OFF, STILL_OFF_RST},
		'{ADDR_SPEED_THR, SPEED_THR_RST}, '{ADDR_OFF_WAIT, OFF_WAIT_RST}, '{ADDR_DO_CFG, DO_CFG_RST},
		'{ADDR_STATUS, 16'h0000}, '{3'h6, 16'h0000}};

	servo_brake_sequencer dut_u (.mclk(mclk), .arst_n(arst_n), .req(req), .rdata(rdata),
		.servo_enable(servo_enable), .motor_speed(motor_speed), .drive_fault(drive_fault),
		.do_pins(do_pins), .motor_power(motor_power), .cmd_ready(cmd_ready));
	brake_partner motor_u (.mclk(mclk), .arst_n(arst_n), .brake_drv(do_pins[2]), .power(motor_power),
		.cmd_ready(cmd_ready), .spin(spin), .speed(motor_speed));

	// clock, 25 ns period
	always #12.5 mclk = ~mclk;

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : cyc
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge mclk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		req <= '0;
	endtask : wr
	task automatic rd(input logic [2:0] a, input logic [15:0] exp);
		@(posedge mclk);
		req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		req <= '0;
		#1;
		chk("rdata", exp, rdata);
	endtask : rd
	task automatic complete_run;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : complete_run

	// watchdog past the two one-millisecond waits
	initial begin
		repeat (95000) @(posedge mclk);
		err_count++;
		complete_run();
	end

	// main sequence
	initial begin
		repeat (12) @(posedge mclk);
		arst_n <= 1'b1;
		foreach (rows[i]) rd(rows[i].addr, rows[i].exp);
		wr(ADDR_DO_CFG, 16'h120A);
		cyc(2);
		chk("inverted idle pin", 16'h0004, {8'h00, do_pins});
		wr(ADDR_DO_CFG, 16'h1202);
		wr(ADDR_CMD_DELAY, 16'h0000);
		wr(ADDR_STILL_OFF, 16'h0001);
		wr(ADDR_OFF_WAIT, 16'h0064);
		wr(ADDR_STATUS, 16'h0007);
		rd(ADDR_STATUS, 16'h0000);
		// standstill shutdown with a 1 ms power-off delay
		@(posedge mclk);
		servo_enable <= 1'b1;
		cyc(2);
		chk("brake on", 16'h0004, {8'h00, do_pins});
		chk("power on", 16'h0001, {15'h0, motor_power});
		@(posedge mclk);
		servo_enable <= 1'b0;
		cyc(2);
		chk("still brake off", 16'h0000, {8'h00, do_pins});
		chk("still power held", 16'h0001, {15'h0, motor_power});
		cyc(TICK_CYCLES - 10);
		chk("power near expiry", 16'h0001, {15'h0, motor_power});
		cyc(20);
		chk("still power off", 16'h0000, {15'h0, motor_power});
		// rotating shutdown released by a raised threshold
		@(posedge mclk);
		servo_enable <= 1'b1;
		spin <= 1'b1;
		cyc(4);
		rd(ADDR_STATUS, {10'h000, 3'b111, ST_RUN});
		chk("cmd ready", 16'h0001, {15'h0, cmd_ready});
		@(posedge mclk);
		servo_enable <= 1'b0;
		cyc(8);
		chk("rot brake held", 16'h0004, {8'h00, do_pins});
		chk("cmd ready dropped", 16'h0000, {15'h0, cmd_ready});
		wr(ADDR_SPEED_THR, 16'h0258);
		cyc(3);
		chk("rot brake off", 16'h0000, {8'h00, do_pins});
		chk("rot power held", 16'h0001, {15'h0, motor_power});
		// fault drops power, and enable is ignored while it stands
		@(posedge mclk);
		drive_fault <= 1'b1;
		cyc(2);
		chk("fault power", 16'h0000, {15'h0, motor_power});
		@(posedge mclk);
		servo_enable <= 1'b1;
		cyc(4);
		chk("fault brake", 16'h0000, {8'h00, do_pins});
		// rotating shutdown released by the 1 ms wait expiring
		wr(ADDR_SPEED_THR, SPEED_THR_RST);
		wr(ADDR_OFF_WAIT, 16'h0001);
		@(posedge mclk);
		drive_fault <= 1'b0;
		cyc(6);
		chk("restart ready", 16'h0001, {15'h0, cmd_ready});
		@(posedge mclk);
		servo_enable <= 1'b0;
		cyc(TICK_CYCLES - 10);
		chk("wait brake held", 16'h0004, {8'h00, do_pins});
		cyc(20);
		chk("wait brake off", 16'h0000, {8'h00, do_pins});
		chk("wait power held", 16'h0001, {15'h0, motor_power});
		complete_run();
	end
endmodule : servo_brake_sequencer_tb
`default_nettype wire
